/* File: chglim_map.vh */
// register offsets, field layouts, reset codes and limits for the charger limit registers
`ifndef CHGLIM_MAP_VH
`define CHGLIM_MAP_VH

// register offsets (byte addresses on the management bus)
`define CHGLIM_OFS_SYSMIN   8'h00
`define CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_HI  8'h01
`define CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_LO  8'h02
`define CHGLIM_OFS_CHARGE_CURRENT_TARGET_HI  8'h03
`define CHGLIM_OFS_CHARGE_CURRENT_TARGET_LO  8'h04
`define CHGLIM_OFS_VFLOOR   8'h05

// field widths
`define CHGLIM_SYSMIN_W 6
`define CHGLIM_CHARGE_VOLTAGE_TARGET_W   11
`define CHGLIM_CHARGE_CURRENT_TARGET_W   9
`define CHGLIM_VFLOOR_W 8

// minimum system voltage: 2500 mV offset, 250 mV step, codes 0..54 valid
`define CHGLIM_SYSMIN_MAX 6'h36
`define CHGLIM_SYSMIN_1S  6'h04
`define CHGLIM_SYSMIN_2S  6'h12
`define CHGLIM_SYSMIN_3S  6'h1a
`define CHGLIM_SYSMIN_4S  6'h26

// charge voltage: 10 mV step, 3000 mV..18800 mV
`define CHGLIM_CHARGE_VOLTAGE_TARGET_MIN 11'h12c
`define CHGLIM_CHARGE_VOLTAGE_TARGET_MAX 11'h758
`define CHGLIM_CHARGE_VOLTAGE_TARGET_1S  11'h1a4
`define CHGLIM_CHARGE_VOLTAGE_TARGET_2S  11'h348
`define CHGLIM_CHARGE_VOLTAGE_TARGET_3S  11'h4ec
`define CHGLIM_CHARGE_VOLTAGE_TARGET_4S  11'h690

// charge current: 10 mA step, 50 mA..3000 mA, default 1 A
`define CHGLIM_CHARGE_CURRENT_TARGET_MIN 9'h005
`define CHGLIM_CHARGE_CURRENT_TARGET_MAX 9'h12c
`define CHGLIM_CHARGE_CURRENT_TARGET_DEF 9'h064

// input voltage floor: 100 mV step, 3600 mV..22000 mV
`define CHGLIM_VFLOOR_MIN 8'h24
`define CHGLIM_VFLOOR_MAX 8'hdc
`define CHGLIM_VFLOOR_DEF 8'h24

`endif

/* File: chglim_clamp.v */
// range check for one written code against low and high limits
`timescale 1ns/1ps
`default_nettype none
module chglim_clamp #(
  parameter W = 8
) (
  input wire [W-1:0] code,     // code being written
  input wire [W-1:0] lo,       // least valid code
  input wire [W-1:0] hi,       // largest valid code
  input wire chk_lo,           // field is clamped low
  input wire chk_hi,           // field is clamped high
  output wire accept           // write may be stored
);
  // clamped fields simply refuse out-of-range codes, no saturation
  assign accept = !(chk_lo && (code < lo)) && !(chk_hi && (code > hi));
endmodule // chglim_clamp
`default_nettype wire

/* File: chglim_regs.v */
// charger regulation limit registers: byte-wide register bank with defaults
//
// How it works
// - sysmin code: 2500 mV offset, 250 mV steps
// - power-on sysmin from sensed cell count
// - charge_voltage_target 11 bits, 10 mV; upper bits zero
// - power-on charge_voltage_target from sensed cell count
// - charge_current_target 9 bits, 10 mA; default 64h
// - floor 8 bits, 100 mV; default 24h
// - adapter removal forces floor to 3600 mV
// - adapter plug loads floor from measurement
// - restore and watchdog leave floor alone
// - clamped-low fields drop writes below minimum
// - clamped-high fields drop writes above maximum
`timescale 1ns/1ps
`default_nettype none
`include "chglim_map.vh"
module chglim_regs (
  input wire clk,                 // 200 MHz system clock
  input wire rstn,                // async reset, active low
  input wire [7:0] reg_addr,      // register byte offset
  input wire reg_wr,              // one-cycle write strobe
  input wire [7:0] reg_wdata,     // write byte
  input wire reg_rd,              // one-cycle read strobe
  output reg [7:0] reg_rdata_ff,  // read byte, valid cycle after reg_rd
  input wire [1:0] cell_config_pin, // sensed cell count, 0=1s .. 3=4s
  input wire por_load,            // pulse: latch cell count defaults
  input wire reg_restore,         // pulse: register-restore command
  input wire wdog_expire,         // pulse: watchdog timer expired
  input wire adapter_plug,        // pulse: adapter connected
  input wire adapter_unplug,      // pulse: adapter removed
  input wire [7:0] input_supply_voltage, // floor code derived from input measurement
  output reg [5:0] min_system_voltage_setting_ff, // live sysmin code
  output reg [10:0] charge_voltage_target_ff,     // live charge_voltage_target code
  output reg [8:0] charge_current_target_ff,      // live charge_current_target code
  output reg [7:0] input_voltage_floor_ff         // live floor code
);

  // -------------------------------------------------------------------------
  // defaults
  // -------------------------------------------------------------------------
  reg [1:0] cells_ff; // cell count caught at power-on load
  reg [1:0] nxt_cells;

  function [5:0] sysmin_def;
    input [1:0] c;
    begin
      case (c)
        2'h0: sysmin_def = `CHGLIM_SYSMIN_1S;
        2'h1: sysmin_def = `CHGLIM_SYSMIN_2S;
        2'h2: sysmin_def = `CHGLIM_SYSMIN_3S;
        default: sysmin_def = `CHGLIM_SYSMIN_4S;
      endcase
    end
  endfunction

  function [10:0] charge_voltage_target_def;
    input [1:0] c;
    begin
      case (c)
        2'h0: charge_voltage_target_def = `CHGLIM_CHARGE_VOLTAGE_TARGET_1S;
        2'h1: charge_voltage_target_def = `CHGLIM_CHARGE_VOLTAGE_TARGET_2S;
        2'h2: charge_voltage_target_def = `CHGLIM_CHARGE_VOLTAGE_TARGET_3S;
        default: charge_voltage_target_def = `CHGLIM_CHARGE_VOLTAGE_TARGET_4S;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------------
  // write decode and range checks
  // -------------------------------------------------------------------------
  // one comparator shape shared by every write strobe
  function ofs_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      ofs_hit = (a == ofs);
    end
  endfunction

  wire wr_sysmin = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_SYSMIN);
  wire wr_charge_voltage_target_hi = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_HI);
  wire wr_charge_voltage_target_lo = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_LO);
  wire wr_charge_current_target_hi = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_CHARGE_CURRENT_TARGET_HI);
  wire wr_charge_current_target_lo = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_CHARGE_CURRENT_TARGET_LO);
  wire wr_floor = reg_wr && ofs_hit(reg_addr, `CHGLIM_OFS_VFLOOR);

  // byte writes merge into the live word; check applies to the merged code
  wire [5:0] cand_sysmin = reg_wdata[5:0]; // reserved bits 7:6 dropped
  wire [10:0] cand_charge_voltage_target = wr_charge_voltage_target_hi ? {charge_voltage_target_ff[10:8], reg_wdata} :
                                       {reg_wdata[2:0], charge_voltage_target_ff[7:0]};
  wire [8:0] cand_charge_current_target = wr_charge_current_target_hi ? {charge_current_target_ff[8], reg_wdata} :
                                      {reg_wdata[0], charge_current_target_ff[7:0]};
  wire ok_sysmin;
  wire ok_charge_voltage_target;
  wire ok_charge_current_target;
  wire ok_floor;

  // sysmin is clamped high only; the low limit is never armed
  chglim_clamp #(.W(6)) u_clamp_sysmin (
    .code(cand_sysmin),
    .lo(6'h00),
    .hi(`CHGLIM_SYSMIN_MAX),
    .chk_lo(1'b0),
    .chk_hi(1'b1),
    .accept(ok_sysmin)
  );

  // charge_voltage_target is clamped low only, so codes above the range are still taken
  chglim_clamp #(.W(11)) u_clamp_charge_voltage_target (
    .code(cand_charge_voltage_target),
    .lo(`CHGLIM_CHARGE_VOLTAGE_TARGET_MIN),
    .hi(`CHGLIM_CHARGE_VOLTAGE_TARGET_MAX),
    .chk_lo(1'b1),
    .chk_hi(1'b0),
    .accept(ok_charge_voltage_target)
  );

  // charge_current_target is clamped low only
  chglim_clamp #(.W(9)) u_clamp_charge_current_target (
    .code(cand_charge_current_target),
    .lo(`CHGLIM_CHARGE_CURRENT_TARGET_MIN),
    .hi(`CHGLIM_CHARGE_CURRENT_TARGET_MAX),
    .chk_lo(1'b1),
    .chk_hi(1'b0),
    .accept(ok_charge_current_target)
  );

  // floor is clamped low only; a code loaded on plug-in bypasses this check
  chglim_clamp #(.W(8)) u_clamp_floor (
    .code(reg_wdata),
    .lo(`CHGLIM_VFLOOR_MIN),
    .hi(`CHGLIM_VFLOOR_MAX),
    .chk_lo(1'b1),
    .chk_hi(1'b0),
    .accept(ok_floor)
  );

  // -------------------------------------------------------------------------
  // event qualification
  // -------------------------------------------------------------------------
  // power-on load outranks everything, so every other event is masked by it
  wire ev_restore = reg_restore && !por_load;
  wire ev_charge_current_target_reload = (reg_restore || wdog_expire) && !por_load;
  wire ev_unplug = adapter_unplug && !por_load;
  // unplug wins over a same-cycle plug, so the floor ends at its lowest code
  wire ev_plug = adapter_plug && !adapter_unplug && !por_load;

  // accepted software writes; hardware events still override them below
  wire take_sysmin = wr_sysmin && ok_sysmin;
  wire take_charge_voltage_target = (wr_charge_voltage_target_hi || wr_charge_voltage_target_lo) && ok_charge_voltage_target;
  wire take_charge_current_target = (wr_charge_current_target_hi || wr_charge_current_target_lo) && ok_charge_current_target;
  wire take_floor = wr_floor && ok_floor;

  // -------------------------------------------------------------------------
  // next-state logic, priority: power-on load, restore/watchdog, adapter, write
  // -------------------------------------------------------------------------
  reg [5:0] nxt_sysmin;
  reg [10:0] nxt_charge_voltage_target;
  reg [8:0] nxt_charge_current_target;
  reg [7:0] nxt_floor;

  // cell pin latched on each por_load, so pin changes between loads have no effect
  always @* begin
    nxt_cells = cells_ff;
    if (por_load) begin
      nxt_cells = cell_config_pin;
    end
  end

  // sysmin: power-on and restore reload the cell-count default
  always @* begin
    nxt_sysmin = min_system_voltage_setting_ff;
    if (por_load) begin
      nxt_sysmin = sysmin_def(cell_config_pin);
    end else if (ev_restore) begin
      nxt_sysmin = sysmin_def(cells_ff);
    end else if (take_sysmin) begin
      nxt_sysmin = cand_sysmin;
    end
  end

  // charge_voltage_target: same reload pattern as sysmin
  always @* begin
    nxt_charge_voltage_target = charge_voltage_target_ff;
    if (por_load) begin
      nxt_charge_voltage_target = charge_voltage_target_def(cell_config_pin);
    end else if (ev_restore) begin
      nxt_charge_voltage_target = charge_voltage_target_def(cells_ff);
    end else if (take_charge_voltage_target) begin
      nxt_charge_voltage_target = cand_charge_voltage_target;
    end
  end

  // charge_current_target: one fixed default, reloaded by restore and by watchdog alike
  always @* begin
    nxt_charge_current_target = charge_current_target_ff;
    if (por_load) begin
      nxt_charge_current_target = `CHGLIM_CHARGE_CURRENT_TARGET_DEF;
    end else if (ev_charge_current_target_reload) begin
      nxt_charge_current_target = `CHGLIM_CHARGE_CURRENT_TARGET_DEF;
    end else if (take_charge_current_target) begin
      nxt_charge_current_target = cand_charge_current_target;
    end
  end

  // floor: only power-on load and adapter events move it in hardware, never restore or watchdog
  always @* begin
    nxt_floor = input_voltage_floor_ff;
    if (por_load) begin
      nxt_floor = `CHGLIM_VFLOOR_DEF;
    end else if (ev_unplug) begin
      nxt_floor = `CHGLIM_VFLOOR_DEF;
    end else if (ev_plug) begin
      nxt_floor = input_supply_voltage;
    end else if (take_floor) begin
      nxt_floor = reg_wdata;
    end
  end

  // -------------------------------------------------------------------------
  // register state
  // -------------------------------------------------------------------------
  // cell count: 1s until the first power-on load
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cells_ff <= 2'h0;
    end else begin
      cells_ff <= nxt_cells;
    end
  end

  // sysmin resets to the 1s code, the lowest default, until por_load
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      min_system_voltage_setting_ff <= `CHGLIM_SYSMIN_1S;
    end else begin
      min_system_voltage_setting_ff <= nxt_sysmin;
    end
  end

  // charge_voltage_target resets to the 1s code so a reset never overcharges a single cell
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charge_voltage_target_ff <= `CHGLIM_CHARGE_VOLTAGE_TARGET_1S;
    end else begin
      charge_voltage_target_ff <= nxt_charge_voltage_target;
    end
  end

  // charge_current_target resets to 1 A whatever the cell count
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charge_current_target_ff <= `CHGLIM_CHARGE_CURRENT_TARGET_DEF;
    end else begin
      charge_current_target_ff <= nxt_charge_current_target;
    end
  end

  // floor resets to its lowest code
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_voltage_floor_ff <= `CHGLIM_VFLOOR_DEF;
    end else begin
      input_voltage_floor_ff <= nxt_floor;
    end
  end

  // -------------------------------------------------------------------------
  // register images
  // -------------------------------------------------------------------------
  // reserved bits are tied low here rather than stored, so no write reaches them
  wire [7:0] img_sysmin = {2'h0, min_system_voltage_setting_ff};
  wire [15:0] img_charge_voltage_target = {5'h00, charge_voltage_target_ff};
  wire [15:0] img_charge_current_target = {7'h00, charge_current_target_ff};
  wire [7:0] img_floor = input_voltage_floor_ff;

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  reg [7:0] nxt_rdata;

  // unlisted offsets read zero; the host is expected not to write them
  always @* begin
    case (reg_addr)
      `CHGLIM_OFS_SYSMIN: nxt_rdata = img_sysmin;
      `CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_HI: nxt_rdata = img_charge_voltage_target[7:0];
      `CHGLIM_OFS_CHARGE_VOLTAGE_TARGET_LO: nxt_rdata = img_charge_voltage_target[15:8];
      `CHGLIM_OFS_CHARGE_CURRENT_TARGET_HI: nxt_rdata = img_charge_current_target[7:0];
      `CHGLIM_OFS_CHARGE_CURRENT_TARGET_LO: nxt_rdata = img_charge_current_target[15:8];
      `CHGLIM_OFS_VFLOOR: nxt_rdata = img_floor;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule // chglim_regs
`default_nettype wire

/* File: chglim_assertions.sv */
// checker for the charger limit register bank
`timescale 1ns/1ps
`default_nettype none
module chglim_chk (
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic [7:0] reg_addr, // offset
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_wdata, // byte
  input wire logic por_load, // por
  input wire logic reg_restore, // restore
  input wire logic wdog_expire, // watchdog
  input wire logic adapter_plug, // plug
  input wire logic adapter_unplug, // unplug
  input wire logic [7:0] input_supply_voltage, // plug code
  input wire logic [5:0] min_system_voltage_setting_ff, // sysmin
  input wire logic [10:0] charge_voltage_target_ff, // charge_voltage_target
  input wire logic [8:0] charge_current_target_ff, // charge_current_target
  input wire logic [7:0] input_voltage_floor_ff // floor
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // events that may legally move the floor
  wire logic no_ev = !por_load && !adapter_plug && !adapter_unplug;
  a_unplug_floor: assert property (
    adapter_unplug && !por_load |=> input_voltage_floor_ff == 8'h24) else $error("floor kept on unplug");
  a_plug_floor: assert property (
    adapter_plug && no_ev || adapter_plug && !por_load && !adapter_unplug
    |=> input_voltage_floor_ff == $past(input_supply_voltage)) else $error("floor not loaded on plug");
  a_floor_kept: assert property (
    (reg_restore || wdog_expire) && no_ev && !reg_wr |=> $stable(input_voltage_floor_ff)) else $error("floor moved");
  a_floor_low: assert property (
    reg_wr && reg_addr == 8'h05 && reg_wdata < 8'h24 && no_ev |=> $stable(input_voltage_floor_ff))
    else $error("low floor write stored");
  a_sysmin_high: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[5:0] > 6'h36 && !por_load && !reg_restore
    |=> $stable(min_system_voltage_setting_ff)) else $error("high sysmin write stored");
  a_charge_current_target_reload: assert property (
    (reg_restore || wdog_expire) && !por_load |=> charge_current_target_ff == 9'h064) else $error("charge_current_target not 1 A");
  a_charge_current_target_range: assert property (
    charge_current_target_ff >= 9'h005 && charge_current_target_ff <= 9'h12c) else $error("charge_current_target out of range");
  a_charge_voltage_target_range: assert property (
    charge_voltage_target_ff >= 11'h12c && charge_voltage_target_ff <= 11'h758) else $error("charge_voltage_target out of range");
endmodule // chglim_chk
bind chglim_regs chglim_chk u_chk (.*);
`default_nettype wire

/* File: chglim_host.sv */
// host-side register bus model for the charger limit bank
`timescale 1ns/1ps
`default_nettype none
module chglim_host (
  input wire logic clk, // clock
  output logic [7:0] reg_addr = 8'h00, // offset
  output logic reg_wr = 1'b0, // write strobe
  output logic [7:0] reg_wdata = 8'h00, // byte
  output logic reg_rd = 1'b0, // read strobe
  input wire logic [7:0] reg_rdata_ff // read byte
);
  // one-cycle write; unlisted offsets are only ever read, never written
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data lands on the taking edge, so sample just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_ff;
  endtask
endmodule // chglim_host
`default_nettype wire

/* File: chglim_regs_tb.sv */
// self-checking testbench for the charger limit register bank
`timescale 1ns/1ps
`default_nettype none
module chglim_regs_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] cells = 2'h0;
  logic [4:0] ev = 5'h00; // por, restore, wdog, plug, unplug
  logic [7:0] isv = 8'h00;
  logic [7:0] d;
  wire [7:0] a, wd, rdat, fl;
  wire w, r;
  wire [5:0] sm;
  wire [10:0] vr;
  wire [8:0] ic;
  int fails = 0;
  int compares = 0;
  initial forever #2.5 clk = ~clk;
  chglim_host host (.clk(clk), .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rd(r), .reg_rdata_ff(rdat));
  chglim_regs dut (.clk(clk), .rstn(rstn), .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rd(r),
    .reg_rdata_ff(rdat), .cell_config_pin(cells), .por_load(ev[4]), .reg_restore(ev[3]), .wdog_expire(ev[2]),
    .adapter_plug(ev[1]), .adapter_unplug(ev[0]), .input_supply_voltage(isv), .min_system_voltage_setting_ff(sm),
    .charge_voltage_target_ff(vr), .charge_current_target_ff(ic), .input_voltage_floor_ff(fl));
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // event strobes last exactly one cycle
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 5'h00;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    host.rd(ad, d);
    chk("rdata", 11'(d), 11'(e));
  endtask
  task automatic t_reset;
    chk("charge_current_target", 11'(ic), 11'h064);
    chk("floor", 11'(fl), 11'h024);
    rdchk(8'h04, 8'h00);
    rdchk(8'h06, 8'h00);
    $display("reset done");
  endtask
  task automatic t_por;
    int smv[4] = '{3500, 7000, 9000, 12000};
    int vmv[4] = '{4200, 8400, 12600, 16800};
    for (int i = 0; i < 4; i++) begin
      cells <= 2'(i);
      pulse(5'h10);
      chk("sysmin", 11'(sm), 11'((smv[i] - 2500) / 250));
      chk("charge_voltage_target", vr, 11'(vmv[i] / 10));
    end
    $display("power-on done");
  endtask
  task automatic t_write;
    host.wr(8'h05, 8'h50);
    chk("floor", 11'(fl), 11'h050);
    host.wr(8'h05, 8'h23);
    chk("floor", 11'(fl), 11'h050);
    host.wr(8'h00, 8'h37);
    chk("sysmin", 11'(sm), 11'h026);
    host.wr(8'h00, 8'hf6);
    rdchk(8'h00, 8'h36);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'hff);
    rdchk(8'h02, 8'h07);
    host.wr(8'h02, 8'h00);
    chk("charge_voltage_target", vr, 11'h700);
    host.wr(8'h03, 8'h04);
    chk("charge_current_target", 11'(ic), 11'h064);
    $display("write done");
  endtask
  task automatic t_events;
    host.wr(8'h03, 8'hc8);
    pulse(5'h08);
    chk("sysmin", 11'(sm), 11'h026);
    chk("charge_voltage_target", vr, 11'h690);
    chk("charge_current_target", 11'(ic), 11'h064);
    chk("floor", 11'(fl), 11'h050);
    host.wr(8'h03, 8'hc8);
    pulse(5'h04);
    chk("charge_current_target", 11'(ic), 11'h064);
    chk("sysmin", 11'(sm), 11'h026);
    chk("charge_voltage_target", vr, 11'h690);
    chk("floor", 11'(fl), 11'h050);
    isv <= 8'h5a;
    pulse(5'h02);
    chk("floor", 11'(fl), 11'h05a);
    pulse(5'h01);
    chk("floor", 11'(fl), 11'h024);
    rdchk(8'h01, 8'h90);
    rdchk(8'h03, 8'h64);
    rdchk(8'h05, 8'h24);
    $display("events done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_por;
    t_write;
    t_events;
    tally_and_finish;
  end
  // about seventy cycles are expected; give up after twenty thousand
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
endmodule // chglim_regs_tb
`default_nettype wire
